/* File: hdl/eei_pkg.sv */
// Purpose: shared constants and types of the serial memory slave front end
// Assumes: system clock of 125 MHz, bus pins sampled through synchronisers
// Notes:   all timing counts derive from times in their own units
package eei_pkg;
    localparam logic [3:0] DEVICE_TYPE_CODE      = 4'hA;
    localparam int         CLK_PERIOD_NS         = 8;
    localparam int         GLITCH_NS             = 100;
    localparam logic [3:0] GLITCH_CYCLES         =
        4'((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int         POWER_UP_DELAY_MS     = 1;
    localparam int         POWER_UP_CYCLES       =
        POWER_UP_DELAY_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int         PROGRAM_CYCLE_TIME_MS = 5;
    localparam int         PROGRAM_CYCLES        =
        PROGRAM_CYCLE_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int         TIMER_W               = 20;
    localparam int         BYTE_W                = 8;
    localparam int         RX_W                  = 9;
    localparam int         FIFO_DEPTH            = 4;
    localparam logic [3:0] LAST_BIT              = 4'h7;
    localparam logic [1:0] FIRST_ADDR_IDX        = 2'h1;
    localparam logic [1:0] SECOND_ADDR_IDX       = 2'h2;
    localparam logic [1:0] DATA_IDX              = 2'h3;
    localparam logic [7:0] ADDR_HI_MASK          = 8'h7F;
    localparam logic       RW_READ               = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK
    } eei_state_type;
endpackage

/* File: hdl/eei_slave_top.sv */
// Purpose: two-wire slave front end of a byte-wide nonvolatile memory
// Assumes: bus pins and straps are asynchronous to clk
// Notes:   received address and data bytes leave through a small FIFO; a full FIFO nacks them
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// shift-register FIFO: head always sits in slot 0
module eei_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [DEPTH-1:0]            vld;
    } eei_fifo_state_type;

    eei_fifo_state_type q;
    eei_fifo_state_type d;

    always_comb begin
        logic placed;
        placed = 1'b0;
        d = q;
        if (q.vld[0] && outReady) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
                d.vld[i] = q.vld[i+1];
            end
            d.vld[DEPTH-1] = 1'b0;
        end
        if (inValid && !q.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!placed && !d.vld[i]) begin
                    d.mem[i] = inData;
                    d.vld[i] = 1'b1;
                    placed   = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign inReady  = ~q.vld[DEPTH-1];
    assign outValid = q.vld[0];
    assign outData  = q.mem[0];
endmodule

////////////////////////////////////////////////////////////////////////////////
module eei_slave_top
    import eei_pkg::*;
#(
    parameter int unsigned PU_CYCLES   = POWER_UP_CYCLES,
    parameter int unsigned PROG_CYCLES = PROGRAM_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    input  wire logic              writeInhibit,
    input  wire logic              chip_select_strap_0,
    input  wire logic              chip_select_strap_1,
    input  wire logic              chip_select_strap_2,
    output logic [BYTE_W-1:0]      rxData,
    output logic                   rxIsData,
    output logic                   rxValid,
    input  wire logic              rxReady,
    input  wire logic [BYTE_W-1:0] txData,
    output logic                   txTake,
    output logic                   programStart,
    output logic                   busy,
    output logic                   ready,
    output logic                   writeRejected
);
    typedef struct packed {
        logic                scl1;
        logic                scl2;
        logic                sda1;
        logic                sda2;
        logic                wp1;
        logic                wp2;
        logic [2:0]          cs1;
        logic [2:0]          cs2;
        logic                sclF;
        logic                sdaF;
        logic [3:0]          sclCnt;
        logic [3:0]          sdaCnt;
        eei_state_type       state;
        logic [3:0]          bitCnt;
        logic [BYTE_W-1:0]   shift;
        logic                isRead;
        logic [1:0]          byteIdx;
        logic                wpHold;
        logic                wroteData;
        logic                ackNext;
        logic                oe;
        logic                pullLow;
        logic                busy;
        logic [TIMER_W-1:0]  progCnt;
        logic                ready;
        logic [TIMER_W-1:0]  puCnt;
        logic                pushV;
        logic [RX_W-1:0]     pushD;
        logic                progStart;
        logic                txTake;
        logic                wrReject;
    } eei_state_reg_type;

    eei_state_reg_type q;
    eei_state_reg_type d;

    // filtered level only follows raw after it differs long enough
    function automatic logic [4:0] glitchStep(input logic       raw,
                                              input logic       lvl,
                                              input logic [3:0] cnt);
        if (raw == lvl) begin
            glitchStep = {lvl, 4'h0};
        end else if (cnt == GLITCH_CYCLES) begin
            glitchStep = {~lvl, 4'h0};
        end else begin
            glitchStep = {lvl, cnt + 4'h1};
        end
    endfunction

    logic [4:0]        sclStep;
    logic [4:0]        sdaStep;
    logic              sclRise;
    logic              sclFall;
    logic              startC;
    logic              stopC;
    logic              fifoReady;
    logic [BYTE_W-1:0] newByte;

    assign sclStep = glitchStep(q.scl2, q.sclF, q.sclCnt);
    assign sdaStep = glitchStep(q.sda2, q.sdaF, q.sdaCnt);
    assign sclRise = sclStep[4] & ~q.sclF;
    assign sclFall = ~sclStep[4] & q.sclF;
    // data change while clock high is a condition
    assign startC  = ~sdaStep[4] & q.sdaF & q.sclF & sclStep[4];
    assign stopC   = sdaStep[4] & ~q.sdaF & q.sclF & sclStep[4];
    assign newByte = {q.shift[6:0], q.sdaF};

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d           = q;
        d.pushV     = 1'b0;
        d.progStart = 1'b0;
        d.txTake    = 1'b0;
        d.wrReject  = 1'b0;
        d.pullLow   = 1'b0;
        d.scl1      = sclIn;
        d.scl2      = q.scl1;
        d.sda1      = sdaIn;
        d.sda2      = q.sda1;
        d.wp1       = writeInhibit;
        d.wp2       = q.wp1;
        d.cs1       = {chip_select_strap_2, chip_select_strap_1,
                       chip_select_strap_0};
        d.cs2       = q.cs1;
        {d.sclF, d.sclCnt} = sclStep;
        {d.sdaF, d.sdaCnt} = sdaStep;

        if (!q.ready) begin
            d.puCnt = q.puCnt + 1'b1;
            if (q.puCnt == TIMER_W'(PU_CYCLES - 1)) begin
                d.ready = 1'b1;
            end
        end
        if (q.busy) begin
            d.progCnt = q.progCnt + 1'b1;
            if (q.progCnt == TIMER_W'(PROG_CYCLES - 1)) begin
                d.busy = 1'b0;
            end
        end

        if (startC) begin
            d.state     = ST_ADDR;
            d.bitCnt    = 4'h0;
            d.oe        = 1'b0;
            d.byteIdx   = 2'h0;
            d.wroteData = 1'b0;
            d.wpHold    = 1'b0;
        end else if (stopC) begin
            // stop starts programming or returns to standby
            if (q.wroteData && !q.isRead) begin
                d.busy      = 1'b1;
                d.progCnt   = '0;
                d.progStart = 1'b1;
            end
            d.state     = ST_IDLE;
            d.oe        = 1'b0;
            d.wroteData = 1'b0;
        end else begin
            case (q.state)
                ST_IDLE: begin
                    d.oe = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (sclRise) begin
                        d.shift  = newByte;
                        d.bitCnt = q.bitCnt + 4'h1;
                        if (q.bitCnt == LAST_BIT) begin
                            if (q.state == ST_ADDR) begin
                                d.ackNext = newByte[7:4] == DEVICE_TYPE_CODE
                                         && newByte[3:1] == q.cs2
                                         && q.ready && !q.busy;
                                d.isRead  = newByte[0] == RW_READ;
                            end else if (q.byteIdx != DATA_IDX) begin
                                d.ackNext = fifoReady;
                                d.pushV   = fifoReady;
                                d.pushD   = {1'b0,
                                    q.byteIdx == FIRST_ADDR_IDX ?
                                    newByte & ADDR_HI_MASK : newByte};
                            end else begin
                                d.ackNext   = fifoReady & ~q.wpHold;
                                d.pushV     = fifoReady & ~q.wpHold;
                                d.pushD     = {1'b1, newByte};
                                d.wroteData = q.wroteData
                                            | (fifoReady & ~q.wpHold);
                                d.wrReject  = q.wpHold;
                            end
                        end
                    end else if (sclFall && q.bitCnt == 4'h8) begin
                        // pull low in the ninth clock
                        if (q.ackNext) begin
                            d.oe      = 1'b1;
                            d.pullLow = 1'b1;
                            d.state   = ST_ACK;
                        end else begin
                            d.state = ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        d.bitCnt = 4'h0;
                        if (q.byteIdx != DATA_IDX) begin
                            d.byteIdx = q.byteIdx + 2'h1;
                        end
                        if (q.isRead) begin
                            d.state  = ST_TX;
                            d.shift  = txData;
                            d.oe     = ~txData[7];
                            d.txTake = 1'b1;
                        end else begin
                            d.state = ST_RX;
                            d.oe    = 1'b0;
                            if (q.byteIdx == SECOND_ADDR_IDX) begin
                                d.wpHold = q.wp2;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (q.bitCnt == LAST_BIT) begin
                            // release in the ninth clock on read
                            d.oe    = 1'b0;
                            d.state = ST_MACK;
                        end else begin
                            d.bitCnt = q.bitCnt + 4'h1;
                            d.shift  = {q.shift[6:0], 1'b0};
                            d.oe     = ~q.shift[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        d.ackNext = ~q.sdaF;
                    end else if (sclFall) begin
                        if (q.ackNext) begin
                            d.state  = ST_TX;
                            d.bitCnt = 4'h0;
                            d.shift  = txData;
                            d.oe     = ~txData[7];
                            d.txTake = 1'b1;
                        end else begin
                            d.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    d.state = ST_IDLE;
                    d.oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    eei_fifo #(
        .WIDTH (RX_W),
        .DEPTH (FIFO_DEPTH)
    ) rxFifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .inValid  (q.pushV),
        .inReady  (fifoReady),
        .inData   (q.pushD),
        .outValid (rxValid),
        .outData  ({rxIsData, rxData}),
        .outReady (rxReady)
    );

    // open drain, the data level is always low
    assign sdaOut        = q.pullLow & 1'b0;
    assign sdaOe         = q.oe;
    assign txTake        = q.txTake;
    assign programStart  = q.progStart;
    assign busy          = q.busy;
    assign ready         = q.ready;
    assign writeRejected = q.wrReject;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence addrAckSeq;
        $rose(q.state == ST_ACK) && q.byteIdx == 2'h0;
    endsequence

    sequence writeStopSeq;
        stopC && q.wroteData && !q.isRead;
    endsequence

    open_drain_a: assert property (sdaOe |-> !sdaOut)
        else $error("data pin driven high");
    type_code_a: assert property (
        addrAckSeq |-> q.shift[7:4] == DEVICE_TYPE_CODE)
        else $error("ack on wrong type code");
    strap_match_a: assert property (
        addrAckSeq |-> q.shift[3:1] == q.cs2 && sdaOe)
        else $error("ack on wrong strap value");
    busy_nack_a: assert property (addrAckSeq |-> !busy && ready)
        else $error("address acked while busy or not ready");
    start_wake_a: assert property (
        startC |=> q.state == ST_ADDR && !sdaOe && q.bitCnt == 4'h0)
        else $error("start not taken");
    idle_quiet_a: assert property (
        q.state == ST_IDLE && !$past(q.state == ST_TX) |-> !sdaOe)
        else $error("driving while idle");
    program_stop_a: assert property (
        writeStopSeq |=> busy && programStart ##1 !programStart)
        else $error("stop did not start programming");
    program_len_a: assert property (
        busy |-> q.progCnt < TIMER_W'(PROG_CYCLES))
        else $error("programming overran");
    inhibit_a: assert property (
        q.pushV && q.pushD[8] |-> !q.wpHold)
        else $error("write taken while inhibited");
    drive_fall_a: assert property (
        $changed(sdaOe) && !$past(startC || stopC) |-> $past(sclFall))
        else $error("data changed away from falling clock");
    glitch_a: assert property (
        $changed(q.sclF) |-> $past(q.sclCnt) == GLITCH_CYCLES)
        else $error("clock edge passed filter early");
endmodule

/* File: tb/eei_bus_master.sv */
// Purpose: behavioural two-wire bus master facing the slave front end
// Assumes: wire level is resolved outside, with a pull-up to one
// Notes:   each change follows a clk edge by 1 ns; phases last QTR cycles, the clock glitch 10
`timescale 1ns/1ps

module eei_bus_master #(
    // 35-cycle quarters keep SCL near 893 kHz
    parameter int QTR = 35
) (
    input  wire logic clk,
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaPull
);
    initial begin
        scl     = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic wait_q(input int n);
        repeat (n * QTR) @(posedge clk);
        #1;
    endtask

    task automatic start_cond();
        sdaPull = 1'b0;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        sdaPull = 1'b1;
        wait_q(1);
        scl = 1'b0;
        wait_q(1);
    endtask

    task automatic stop_cond();
        sdaPull = 1'b1;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        sdaPull = 1'b0;
        wait_q(2);
    endtask

    // nine bit cells, data changes only while clock low
    task automatic frame(input logic [8:0] out, output logic [8:0] got);
        for (int i = 8; i >= 0; i--) begin
            sdaPull = ~out[i];
            wait_q(1);
            scl = 1'b1;
            wait_q(1);
            got[i] = sdaWire;
            wait_q(1);
            scl = 1'b0;
            wait_q(1);
        end
    endtask

    // 80 ns spike on the clock line while it is low
    task automatic clock_glitch();
        scl = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        scl = 1'b0;
        wait_q(1);
    endtask
endmodule

/* File: tb/eei_tb.sv */
// Purpose: self-checking bench of the slave front end
// Assumes: strap and inhibit pins driven, pull-down modelled as zero
// Notes:   short power-up and program counts keep the run brief
`timescale 1ns/1ps

`define CHK(a, b, m) \
    begin \
        comparisons++; \
        if ((a) !== (b)) begin \
            err_count++; \
            $display("ERROR %0t: %s", $time, m); \
        end \
    end

module tb;
    import eei_pkg::*;
    localparam int PU    = 1500;
    localparam int PROG  = 2000;
    localparam int LIMIT = 90000;

    typedef struct {
        logic [2:0] straps;
        logic [7:0] addr;
        logic       ack;
        logic [7:0] txd;
    } eei_row_type;

    eei_row_type rows [8] = '{
        '{3'h5, 8'hAB, 1'b1, 8'h5C}, '{3'h0, 8'hA1, 1'b1, 8'hC3},
        '{3'h5, 8'hAA, 1'b1, 8'h00}, '{3'h5, 8'hBB, 1'b0, 8'h00},
        '{3'h5, 8'h2B, 1'b0, 8'h00}, '{3'h5, 8'hA9, 1'b0, 8'h00},
        '{3'h5, 8'hAF, 1'b0, 8'h00}, '{3'h5, 8'hA3, 1'b0, 8'h00}};
    logic [7:0] fillBytes [4] = '{8'hFF, 8'h34, 8'h11, 8'h22};
    logic [8:0] fifoExp   [4] = '{9'h07F, 9'h034, 9'h111, 9'h122};

    logic       clk          = 1'b0;
    logic       arstN        = 1'b0;
    logic       writeInhibit = 1'b0;
    logic [2:0] straps       = 3'h5;
    logic       rxReady      = 1'b1;
    logic [7:0] txData       = 8'h00;
    logic       scl, sdaPull, sdaWire, sdaOut, sdaOe;
    logic [7:0] rxData;
    logic       rxIsData, rxValid, txTake, programStart;
    logic       busy, ready, writeRejected;
    int         err_count, comparisons, cycles, progCount, rejCount;
    int         txTakes, busyRun, busyLast, readyWait, highDrive;

    always #4 clk = ~clk;

    assign sdaWire = ~(sdaPull | (sdaOe & ~sdaOut));

    eei_bus_master i_master (
        .clk     (clk),
        .sdaWire (sdaWire),
        .scl     (scl),
        .sdaPull (sdaPull)
    );

    eei_slave_top #(
        .PU_CYCLES   (PU),
        .PROG_CYCLES (PROG)
    ) i_dut (
        .clk                 (clk),
        .arst_n              (arstN),
        .sclIn               (scl),
        .sdaIn               (sdaWire),
        .sdaOut              (sdaOut),
        .sdaOe               (sdaOe),
        .writeInhibit        (writeInhibit),
        .chip_select_strap_0 (straps[0]),
        .chip_select_strap_1 (straps[1]),
        .chip_select_strap_2 (straps[2]),
        .rxData              (rxData),
        .rxIsData            (rxIsData),
        .rxValid             (rxValid),
        .rxReady             (rxReady),
        .txData              (txData),
        .txTake              (txTake),
        .programStart        (programStart),
        .busy                (busy),
        .ready               (ready),
        .writeRejected       (writeRejected)
    );

    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (programStart === 1'b1) progCount++;
        if (writeRejected === 1'b1) rejCount++;
        if (txTake === 1'b1) txTakes++;
        if (sdaOe === 1'b1 && sdaOut !== 1'b0) highDrive++;
        if (ready !== 1'b1) readyWait++;
        if (busy === 1'b1) busyRun++;
        else if (busyRun != 0) begin
            busyLast = busyRun;
            busyRun  = 0;
        end
        if (cycles == LIMIT) begin
            err_count++;
            $display("ERROR %0t: run took too long", $time);
            complete_run();
        end
    end

    task automatic send(input logic st, input logic [7:0] b, output logic ack);
        logic [8:0] g;
        if (st) i_master.start_cond();
        i_master.frame({b, 1'b1}, g);
        ack = ~g[0];
    endtask

    task automatic wait_ready();
        for (int n = 0; n < PU + 20 && ready !== 1'b1; n++)
            @(posedge clk);
        #1;
    endtask

    task automatic wait_idle();
        for (int n = 0; n < PROG + 20 && busy === 1'b1; n++)
            @(posedge clk);
        #1;
    endtask

    initial begin
        logic       ack;
        logic [8:0] got;
        int         base;
        repeat (10) @(posedge clk);
        #1;
        `CHK({sdaOe, ready, busy, rxValid, programStart}, 5'h00, "reset")
        arstN     = 1'b1;
        readyWait = 0;
        send(1'b1, 8'hAA, ack);
        `CHK(ack, 1'b0, "ack before ready")
        i_master.stop_cond();
        wait_ready();
        `CHK(readyWait >= PU && readyWait <= PU + 2, 1'b1, "ready delay")

        foreach (rows[i]) begin
            straps = rows[i].straps;
            txData = rows[i].txd;
            base   = txTakes;
            send(1'b1, rows[i].addr, ack);
            `CHK(ack, rows[i].ack, "address ack")
            if (ack === 1'b1 && rows[i].addr[0] === 1'b1) begin
                i_master.frame(9'h1FE, got);
                `CHK(got[8:1], rows[i].txd, "read byte")
                i_master.frame(9'h1FF, got);
                `CHK(got, {rows[i].txd, 1'b1}, "last byte")
                `CHK(txTakes - base, 2, "byte takes")
            end
            i_master.stop_cond();
            wait_idle();
        end

        straps  = 3'h5;
        rxReady = 1'b0;
        base    = progCount;
        send(1'b1, 8'hAA, ack);
        foreach (fillBytes[i]) begin
            send(1'b0, fillBytes[i], ack);
            `CHK(ack, 1'b1, "fill ack")
        end
        send(1'b0, 8'h33, ack);
        `CHK(ack, 1'b0, "full buffer nack")
        i_master.start_cond();
        i_master.stop_cond();
        `CHK(progCount - base, 0, "discarded write")
        foreach (fifoExp[i]) begin
            `CHK({rxValid, rxIsData, rxData}, {1'b1, fifoExp[i]}, "fifo")
            rxReady = 1'b1;
            @(posedge clk);
            #1;
            rxReady = 1'b0;
        end
        `CHK(rxValid, 1'b0, "fifo empty")
        rxReady = 1'b1;

        send(1'b1, 8'hAA, ack);
        foreach (fillBytes[i]) send(1'b0, fillBytes[i], ack);
        i_master.stop_cond();
        `CHK({progCount - base, busy}, {32'sd1, 1'b1}, "program start")
        send(1'b1, 8'hAA, ack);
        `CHK(ack, 1'b0, "poll while busy")
        i_master.stop_cond();
        wait_idle();
        `CHK(busyLast, PROG, "program length")
        send(1'b1, 8'hAB, ack);
        i_master.frame(9'h1FF, got);
        i_master.stop_cond();
        `CHK({ack, progCount - base}, {1'b1, 32'sd1}, "read idles")

        writeInhibit = 1'b1;
        base = rejCount;
        send(1'b1, 8'hAA, ack);
        send(1'b0, 8'hFF, ack);
        send(1'b0, 8'h34, ack);
        `CHK(ack, 1'b1, "inhibit address ack")
        send(1'b0, 8'h77, ack);
        `CHK({ack, rejCount - base}, {1'b0, 32'sd1}, "inhibited")
        i_master.stop_cond();
        `CHK(busy, 1'b0, "no program")
        writeInhibit = 1'b0;

        i_master.start_cond();
        i_master.clock_glitch();
        i_master.frame({8'hAB, 1'b1}, got);
        `CHK(got[0], 1'b0, "glitch ignored")
        i_master.frame(9'h1FF, got);
        i_master.stop_cond();
        i_master.frame({8'hAB, 1'b1}, got);
        `CHK(got[0], 1'b1, "no start")
        i_master.stop_cond();

        send(1'b1, 8'hAB, ack);
        `CHK(sdaOe, 1'b1, "drives zero bit")
        arstN = 1'b0;
        #1;
        `CHK({sdaOe, ready}, 2'b00, "brown-out")
        repeat (10) @(posedge clk);
        #1;
        arstN     = 1'b1;
        readyWait = 0;
        i_master.stop_cond();
        wait_ready();
        send(1'b1, 8'hAB, ack);
        `CHK(ack, 1'b1, "after brown-out")
        i_master.frame(9'h1FF, got);
        i_master.stop_cond();
        `CHK(highDrive, 0, "never drives high")
        complete_run();
    end
endmodule
